// ==== design/coutpd_map.vh ====
// constants for the two-channel current output control block
`ifndef COUTPD_MAP_VH
`define COUTPD_MAP_VH
// ==========================================
// record numbers
`define COUTPD_REC_PARAM 8'h00
`define COUTPD_REC_DIAG4 8'h00
`define COUTPD_REC_DIAG 8'h01
`define COUTPD_REC_FN0 8'h80
`define COUTPD_REC_FN1 8'h81
// ==========================================
// parameter record byte index and length
`define COUTPD_PIX_RSVD 5'h00
`define COUTPD_PIX_WBE 5'h01
`define COUTPD_PIX_FN0 5'h02
`define COUTPD_PIX_FN1 5'h03
`define COUTPD_PAR_LEN 5'h04
// ==========================================
// diagnostic record byte index and lengths
`define COUTPD_DIX_GEN 5'h00
`define COUTPD_DIX_CLASS 5'h01
`define COUTPD_DIX_RSVC 5'h02
`define COUTPD_DIX_INT 5'h03
`define COUTPD_DIX_KIND 5'h04
`define COUTPD_DIX_NBIT 5'h05
`define COUTPD_DIX_NCH 5'h06
`define COUTPD_DIX_GRP 5'h07
`define COUTPD_DIX_CH0 5'h08
`define COUTPD_DIX_CH1 5'h09
`define COUTPD_DIX_TICK0 5'h10
`define COUTPD_DIX_TICK1 5'h11
`define COUTPD_DIX_TICK2 5'h12
`define COUTPD_DIX_TICK3 5'h13
`define COUTPD_DIAG_SHORT 5'h04
`define COUTPD_DIAG_LEN 5'h14
// ==========================================
// reset and fixed values
`define COUTPD_RST_WBE 8'h00
`define COUTPD_RST_FN 8'h31
`define COUTPD_WBE_MASK 8'h03
`define COUTPD_CLASS_ANALOG 4'h5
`define COUTPD_CLASS_CHINFO 4
`define COUTPD_KIND 8'h73
`define COUTPD_NBIT 8'h08
`define COUTPD_NCH 8'h02
// ==========================================
// function codes
`define COUTPD_FN_4_K27 8'h30
`define COUTPD_FN_0_K27 8'h31
`define COUTPD_FN_4_K16 8'h40
`define COUTPD_FN_0_K16 8'h41
`define COUTPD_FN_OFF 8'hFF
// ==========================================
// fault bit positions
`define COUTPD_FLT_PAR 0
`define COUTPD_FLT_WB 4
`define COUTPD_INT_OVF 3
`define COUTPD_INT_COMM 4
`define COUTPD_GEN_INT 0
`define COUTPD_GEN_EXT 1
`define COUTPD_GEN_CH 2
// ==========================================
// scaling figures, current in microamps
`define COUTPD_HI_K27 18'sh07EFF
`define COUTPD_HI_K16 18'sh05000
`define COUTPD_UNDER_K27 18'sh01B00
`define COUTPD_UNDER_K16 18'sh01000
`define COUTPD_FS_K27 36'h000006C00
`define COUTPD_FS_K16 36'h000004000
`define COUTPD_SPAN_0_20 36'h000004E20
`define COUTPD_SPAN_4_20 36'h000003E80
// ==========================================
// microsecond ticker timing
`define COUTPD_TICK_NS 1000
`define COUTPD_CLK_NS 10
`define COUTPD_TICK_CYC (`COUTPD_TICK_NS / `COUTPD_CLK_NS)
`endif

// ==== design/coutpd.v ====
// two-channel current output control: parameters, scaling, diagnostics
`timescale 1ns/10ps
`include "coutpd_map.vh"
// Function
// - wire-break enable bit per channel, default zero
// - parameter record bytes; function codes via 80h/81h
// - function codes default 31h; FFh switches channel off
// - code 31h scales 0-20 mA over 27648
// - code 41h scales 0-20 mA over 16384
// - 0-20 mA ranges clamp negatives to 0 mA
// - code 30h scales 4-20 mA over 27648
// - code 40h scales 4-20 mA over 16384
// - no interrupt; channel fault lights LED, logged
// - parameter errors and enabled wire breaks reported
// - record 01h full diagnostics, 00h first four
// - diagnostic record byte layout and fixed contents
// - module class nibble 0101b, channel info bit
// - channel fault bit 0 parameter, 4 wire break
// - group fault bit per channel group
// - internal fault bits overflow and communication error
module coutpd
(
    input wire i_mclk,
    input wire i_srst,
    input wire [7:0] i_rec_num,
    input wire [4:0] i_rec_idx,
    input wire i_rec_wr,
    input wire i_rec_rd,
    input wire [7:0] i_rec_wdata,
    output reg [7:0] o_rec_rdata,
    output reg o_rec_ack,
    output reg o_rec_err,
    input wire [1:0] i_aout_we,
    input wire [15:0] i_aout_data,
    input wire [1:0] i_wire_open,
    input wire i_diag_ovf,
    input wire i_comm_err,
    output reg [15:0] o_ch0_ua,
    output reg [15:0] o_ch1_ua,
    output reg [1:0] o_ch_active,
    output reg [1:0] o_ch_err_led,
    output reg o_grp_err_led
);

// ==========================================
// functions
// true for one of the four scaling codes
function coutpd_fn_ok;
    input [7:0] fn;
    begin
        coutpd_fn_ok = (fn == `COUTPD_FN_4_K27) || (fn == `COUTPD_FN_0_K27) ||
            (fn == `COUTPD_FN_4_K16) || (fn == `COUTPD_FN_0_K16);
    end
endfunction

// output word to microamps; off or unknown codes give zero
function [15:0] coutpd_scale;
    input [7:0] fn;
    input [15:0] d;
    reg signed [17:0] v;
    reg signed [17:0] lo;
    reg signed [17:0] hi;
    reg [17:0] u;
    reg [35:0] p;
    begin
        v = {{2{d[15]}}, d};
        lo = 18'sd0;
        hi = 18'sd0;
        p = 36'h0;
        // range limits per code; 0-20 ranges have no underrange
        case (fn)
            `COUTPD_FN_4_K27:
            begin
                lo = -`COUTPD_UNDER_K27;
                hi = `COUTPD_HI_K27;
            end
            `COUTPD_FN_0_K27:
            begin
                lo = 18'sd0;
                hi = `COUTPD_HI_K27;
            end
            `COUTPD_FN_4_K16:
            begin
                lo = -`COUTPD_UNDER_K16;
                hi = `COUTPD_HI_K16;
            end
            `COUTPD_FN_0_K16:
            begin
                lo = 18'sd0;
                hi = `COUTPD_HI_K16;
            end
            default: hi = 18'sd0; // off or unknown code: both limits stay zero
        endcase
        // clamp rather than wrap: values past the limits saturate
        if (v < lo)
            v = lo;
        if (v > hi)
            v = hi;
        // shift so the bottom of the range becomes zero
        u = v - lo;
        // divisions are by constants, so they fold into multipliers
        case (fn)
            `COUTPD_FN_4_K27:
                p = ({18'h0, u} * `COUTPD_SPAN_4_20) / `COUTPD_FS_K27;
            `COUTPD_FN_0_K27:
                p = ({18'h0, u} * `COUTPD_SPAN_0_20) / `COUTPD_FS_K27;
            `COUTPD_FN_4_K16:
                p = ({18'h0, u} * `COUTPD_SPAN_4_20) / `COUTPD_FS_K16;
            `COUTPD_FN_0_K16:
                p = ({18'h0, u} * `COUTPD_SPAN_0_20) / `COUTPD_FS_K16;
            default:
                p = 36'h0;
        endcase
        coutpd_scale = p[15:0];
    end
endfunction

// ==========================================
// state
reg [7:0] wbe_r; // wire-break enable byte
reg [7:0] fn0_r; // function code channel 0
reg [7:0] fn1_r; // function code channel 1
reg [15:0] aout0_r; // output word channel 0
reg [15:0] aout1_r; // output word channel 1
reg [1:0] wo_s1_r; // wire-open sync, first stage
reg [1:0] wo_s2_r; // wire-open sync, second stage
reg [7:0] flt0_r; // channel 0 fault byte
reg [7:0] flt1_r; // channel 1 fault byte
reg [7:0] int_r; // internal fault byte
reg [6:0] pre_r; // cycle prescaler for the ticker
reg [31:0] tick_r; // microsecond ticker
reg [31:0] snap_r; // ticker copy taken when byte 16 is read
reg [7:0] flt0_nxt;
reg [7:0] flt1_nxt;
reg [7:0] rbyte; // diagnostic byte selected by index
wire [1:0] fn_ok; // channel has a valid scaling code
wire [1:0] fn_off; // channel switched off
wire [7:0] grp; // group fault byte
wire [7:0] gen; // general fault byte
wire [7:0] mclass; // module class byte
wire wr_ok; // write hits a writable byte
wire rd_diag; // read hits the diagnostic record
wire rd_fn; // read of a function code record

assign fn_ok = {coutpd_fn_ok(fn1_r), coutpd_fn_ok(fn0_r)};
assign fn_off = {fn1_r == `COUTPD_FN_OFF, fn0_r == `COUTPD_FN_OFF};
assign grp = {6'h00, |flt1_r, |flt0_r};
assign mclass = {3'h0, 1'b1, `COUTPD_CLASS_ANALOG};
// general byte: internal, external and channel summary bits
assign gen = {5'h00, |grp, |grp, |int_r};

// ==========================================
// record decode
// a write goes to the parameter record or a function code record
assign wr_ok = ((i_rec_num == `COUTPD_REC_PARAM) && (i_rec_idx < `COUTPD_PAR_LEN)) ||
    (((i_rec_num == `COUTPD_REC_FN0) || (i_rec_num == `COUTPD_REC_FN1)) &&
    (i_rec_idx == 5'h00));
// record 00h read serves only the first four diagnostic bytes
assign rd_diag = ((i_rec_num == `COUTPD_REC_DIAG) && (i_rec_idx < `COUTPD_DIAG_LEN)) ||
    ((i_rec_num == `COUTPD_REC_DIAG4) && (i_rec_idx < `COUTPD_DIAG_SHORT));
assign rd_fn = ((i_rec_num == `COUTPD_REC_FN0) || (i_rec_num == `COUTPD_REC_FN1)) &&
    (i_rec_idx == 5'h00);

// diagnostic byte mux in record order
always @*
begin
    rbyte = 8'h00;
    case (i_rec_idx)
        `COUTPD_DIX_GEN: rbyte = gen;
        `COUTPD_DIX_CLASS: rbyte = mclass;
        `COUTPD_DIX_INT: rbyte = int_r;
        `COUTPD_DIX_KIND: rbyte = `COUTPD_KIND;
        `COUTPD_DIX_NBIT: rbyte = `COUTPD_NBIT;
        `COUTPD_DIX_NCH: rbyte = `COUTPD_NCH;
        `COUTPD_DIX_GRP: rbyte = grp;
        `COUTPD_DIX_CH0: rbyte = flt0_r;
        `COUTPD_DIX_CH1: rbyte = flt1_r;
        `COUTPD_DIX_TICK0: rbyte = tick_r[7:0];
        // upper bytes come from the copy so the word is coherent
        `COUTPD_DIX_TICK1: rbyte = snap_r[15:8];
        `COUTPD_DIX_TICK2: rbyte = snap_r[23:16];
        `COUTPD_DIX_TICK3: rbyte = snap_r[31:24];
        // reserved bytes and reserved channel faults
        default: rbyte = 8'h00;
    endcase
end

// ==========================================
// fault evaluation
// faults are levels; they clear as soon as the cause is gone
always @*
begin
    flt0_nxt = 8'h00;
    flt1_nxt = 8'h00;
    flt0_nxt[`COUTPD_FLT_PAR] = ~fn_ok[0] & ~fn_off[0];
    flt1_nxt[`COUTPD_FLT_PAR] = ~fn_ok[1] & ~fn_off[1];
    // only enabled, driving channels can see a wire break
    flt0_nxt[`COUTPD_FLT_WB] = wbe_r[0] & fn_ok[0] & wo_s2_r[0];
    flt1_nxt[`COUTPD_FLT_WB] = wbe_r[1] & fn_ok[1] & wo_s2_r[1];
end

// ==========================================
// parameter and output word registers
always @(posedge i_mclk)
begin
    if (i_srst)
    begin
        wbe_r <= `COUTPD_RST_WBE;
        fn0_r <= `COUTPD_RST_FN;
        fn1_r <= `COUTPD_RST_FN;
        aout0_r <= 16'h0000;
        aout1_r <= 16'h0000;
    end
    else
    begin
        // parameter writes; the reserved byte is taken and dropped
        if (i_rec_wr && wr_ok)
        begin
            if (i_rec_num == `COUTPD_REC_FN0)
                fn0_r <= i_rec_wdata;
            else if (i_rec_num == `COUTPD_REC_FN1)
                fn1_r <= i_rec_wdata;
            else if (i_rec_idx == `COUTPD_PIX_WBE)
                wbe_r <= i_rec_wdata & `COUTPD_WBE_MASK;
            else if (i_rec_idx == `COUTPD_PIX_FN0)
                fn0_r <= i_rec_wdata;
            else if (i_rec_idx == `COUTPD_PIX_FN1)
                fn1_r <= i_rec_wdata;
        end
        // output image words, one per channel
        if (i_aout_we[0])
            aout0_r <= i_aout_data;
        if (i_aout_we[1])
            aout1_r <= i_aout_data;
    end
end

// ==========================================
// channel outputs and diagnostics
// the wire-open pins are asynchronous, hence two stages
always @(posedge i_mclk)
begin
    if (i_srst)
    begin
        wo_s1_r <= 2'h0;
        wo_s2_r <= 2'h0;
        flt0_r <= 8'h00;
        flt1_r <= 8'h00;
        int_r <= 8'h00;
        o_ch0_ua <= 16'h0000;
        o_ch1_ua <= 16'h0000;
        o_ch_active <= 2'h0;
        o_ch_err_led <= 2'h0;
        o_grp_err_led <= 1'b0;
    end
    else
    begin
        wo_s1_r <= i_wire_open;
        wo_s2_r <= wo_s1_r;
        flt0_r <= flt0_nxt;
        flt1_r <= flt1_nxt;
        int_r <= {3'h0, i_comm_err, i_diag_ovf, 3'h0};
        o_ch0_ua <= coutpd_scale(fn0_r, aout0_r);
        o_ch1_ua <= coutpd_scale(fn1_r, aout1_r);
        o_ch_active <= fn_ok;
        // no interrupt exists; the LEDs show channel faults, not internal ones
        o_ch_err_led <= {|flt1_nxt, |flt0_nxt};
        o_grp_err_led <= |flt0_nxt | |flt1_nxt;
    end
end

// ==========================================
// microsecond ticker
// free-running; wraps after about 71 minutes
always @(posedge i_mclk)
begin
    if (i_srst)
    begin
        pre_r <= 7'h00;
        tick_r <= 32'h0000_0000;
    end
    else if (pre_r == (`COUTPD_TICK_CYC - 1))
    begin
        pre_r <= 7'h00;
        tick_r <= tick_r + 32'h0000_0001;
    end
    else
        pre_r <= pre_r + 7'h01;
end

// ==========================================
// record answer
// one answer per request, one cycle after it; write beats read
always @(posedge i_mclk)
begin
    if (i_srst)
    begin
        o_rec_rdata <= 8'h00;
        o_rec_ack <= 1'b0;
        o_rec_err <= 1'b0;
        snap_r <= 32'h0000_0000;
    end
    else
    begin
        o_rec_ack <= 1'b0;
        o_rec_err <= 1'b0;
        if (i_rec_wr)
        begin
            o_rec_rdata <= 8'h00;
            o_rec_ack <= wr_ok;
            o_rec_err <= ~wr_ok;
        end
        else if (i_rec_rd)
        begin
            o_rec_ack <= rd_diag | rd_fn;
            o_rec_err <= ~(rd_diag | rd_fn);
            if (rd_diag)
                o_rec_rdata <= rbyte;
            else if (rd_fn && (i_rec_num == `COUTPD_REC_FN0))
                o_rec_rdata <= fn0_r;
            else if (rd_fn)
                o_rec_rdata <= fn1_r;
            else
                o_rec_rdata <= 8'h00;
            // catch the ticker when its low byte is fetched
            if (rd_diag && (i_rec_idx == `COUTPD_DIX_TICK0))
                snap_r <= tick_r;
        end
    end
end

endmodule // coutpd

// ==== testbench/coutpd_properties.sv ====
// checker of record answers and output relations of the current output block
`timescale 1ns/10ps
// ==========================================
// port relations
module coutpd_chk
(
    input wire i_mclk,
    input wire i_srst,
    input wire [7:0] i_rec_num,
    input wire [4:0] i_rec_idx,
    input wire i_rec_wr,
    input wire i_rec_rd,
    input wire [7:0] o_rec_rdata,
    input wire o_rec_ack,
    input wire o_rec_err,
    input wire [15:0] o_ch0_ua,
    input wire [15:0] o_ch1_ua,
    input wire [1:0] o_ch_active,
    input wire [1:0] o_ch_err_led,
    input wire o_grp_err_led
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // a read only counts when no write shares the edge, since writes win
    wire rd_only = i_rec_rd && !i_rec_wr;
    AST_ANSWER: assert property ((i_rec_wr || i_rec_rd) |=> (o_rec_ack ^ o_rec_err))
        else $error("strobe without exactly one answer");
    AST_QUIET: assert property (!(i_rec_wr || i_rec_rd) |=> !o_rec_ack && !o_rec_err)
        else $error("answer without strobe");
    AST_KIND: assert property (rd_only && i_rec_num == 8'h01 && i_rec_idx == 5'h04
        |=> o_rec_rdata == 8'h73) else $error("channel kind byte wrong");
    AST_COUNT: assert property (rd_only && i_rec_num == 8'h01 && i_rec_idx == 5'h06
        |=> o_rec_ack && o_rec_rdata == 8'h02) else $error("channel count byte wrong");
    AST_CLASS: assert property (rd_only && i_rec_num[7:1] == 7'h00 && i_rec_idx == 5'h01
        |=> o_rec_rdata == 8'h15) else $error("module class byte wrong");
    AST_SHORT: assert property (rd_only && i_rec_num == 8'h00 && i_rec_idx > 5'h03
        |=> o_rec_err && o_rec_rdata == 8'h00) else $error("short record overrun accepted");
    AST_GROUP: assert property (o_grp_err_led == (|o_ch_err_led))
        else $error("group indicator disagrees with channels");
    // group byte read back must match the channel indicators of the read edge
    AST_GRPBYTE: assert property (rd_only && i_rec_num == 8'h01 && i_rec_idx == 5'h07
        |=> o_rec_rdata == {6'h00, $past(o_ch_err_led)})
        else $error("group fault byte disagrees with channel indicators");
    AST_OFF: assert property (!o_ch_active[0] |-> o_ch0_ua == 16'h0000)
        else $error("inactive channel 0 drives current");
    AST_OFF1: assert property (!o_ch_active[1] |-> o_ch1_ua == 16'h0000)
        else $error("inactive channel 1 drives current");
    AST_CAP: assert property (o_ch0_ua <= 16'h61A8 && o_ch1_ua <= 16'h61A8)
        else $error("current above 25 mA");
endmodule // coutpd_chk
bind coutpd coutpd_chk u_chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_rec_num(i_rec_num),
    .i_rec_idx(i_rec_idx), .i_rec_wr(i_rec_wr), .i_rec_rd(i_rec_rd), .o_rec_rdata(o_rec_rdata),
    .o_rec_ack(o_rec_ack), .o_rec_err(o_rec_err), .o_ch0_ua(o_ch0_ua), .o_ch1_ua(o_ch1_ua),
    .o_ch_active(o_ch_active), .o_ch_err_led(o_ch_err_led), .o_grp_err_led(o_grp_err_led));

// ==== testbench/coutpd_host.sv ====
// bus coupler model: byte record accesses and per-channel output words
`timescale 1ns/10ps
// ==========================================
// host side of the record bus
module coutpd_host
(
    input wire i_mclk,
    input wire i_rec_ack,
    input wire i_rec_err,
    input wire [7:0] i_rec_rdata,
    output reg [7:0] o_rec_num,
    output reg [4:0] o_rec_idx,
    output reg o_rec_wr,
    output reg o_rec_rd,
    output reg [7:0] o_rec_wdata,
    output reg [1:0] o_aout_we,
    output reg [15:0] o_aout_data
);
    initial
    begin
        {o_rec_num, o_rec_idx, o_rec_wr, o_rec_rd, o_rec_wdata} = 23'h000000;
        o_aout_we = 2'h0;
        o_aout_data = 16'h0000;
    end
    // one-cycle strobe; answer taken at the next falling edge, then lines scrambled
    task acc(input w, input [7:0] num, input [4:0] idx, input [7:0] wd,
             output [7:0] rd, output [1:0] st);
    begin
        @(negedge i_mclk);
        o_rec_wr = w;
        o_rec_rd = !w;
        o_rec_num = num;
        o_rec_idx = idx;
        o_rec_wdata = wd;
        @(negedge i_mclk);
        o_rec_wr = 1'b0;
        o_rec_rd = 1'b0;
        o_rec_num = ~num;
        o_rec_idx = ~idx;
        o_rec_wdata = ~wd;
        rd = i_rec_rdata;
        st = {i_rec_ack, i_rec_err};
    end
    endtask
    // one whole 16-bit word per channel; one-cycle write strobe, then data scrambled
    task word(input ch, input [15:0] d);
    begin
        @(negedge i_mclk);
        o_aout_we = ch ? 2'h2 : 2'h1;
        o_aout_data = d;
        @(negedge i_mclk);
        o_aout_we = 2'h0;
        o_aout_data = ~d;
    end
    endtask
endmodule // coutpd_host

// ==== testbench/coutpd_tb.sv ====
// self-checking bench of the current output control block
`timescale 1ns/10ps
// ==========================================
// bench top
module coutpd_tb;
    localparam [47:0] CODES = 48'h55FF41403130;
    localparam [127:0] CORN = 128'h50004000F000E50080007FFF7EFF6C00;
    localparam [79:0] DIAG = 80'h00000002087300001500;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [1:0] wire_open = 2'h0;
    reg diag_ovf = 1'b0;
    reg comm_err = 1'b0;
    wire [7:0] num, wdata, rdata;
    wire [4:0] idx;
    wire wr, rd_s, ack, err, grp;
    wire [1:0] we, act, led;
    wire [15:0] adat, ua0, ua1;
    integer error_cnt = 0, tests_run = 0, seed = 32'h5BD8, i, k;
    reg [7:0] rd, c;
    reg [1:0] st;
    reg [15:0] d;
    reg [31:0] t0, t1;
    reg ch;
    always #5 clk = ~clk;
    coutpd u_coutpd (.i_mclk(clk), .i_srst(srst), .i_rec_num(num), .i_rec_idx(idx),
        .i_rec_wr(wr), .i_rec_rd(rd_s), .i_rec_wdata(wdata), .o_rec_rdata(rdata),
        .o_rec_ack(ack), .o_rec_err(err), .i_aout_we(we), .i_aout_data(adat),
        .i_wire_open(wire_open), .i_diag_ovf(diag_ovf), .i_comm_err(comm_err),
        .o_ch0_ua(ua0), .o_ch1_ua(ua1), .o_ch_active(act), .o_ch_err_led(led),
        .o_grp_err_led(grp));
    coutpd_host u_host (.i_mclk(clk), .i_rec_ack(ack), .i_rec_err(err), .i_rec_rdata(rdata),
        .o_rec_num(num), .o_rec_idx(idx), .o_rec_wr(wr), .o_rec_rd(rd_s),
        .o_rec_wdata(wdata), .o_aout_we(we), .o_aout_data(adat));
    // ==========================================
    // expectations and comparisons
    function ok(input [7:0] f);
        ok = f == 8'h30 || f == 8'h31 || f == 8'h40 || f == 8'h41;
    endfunction
    // clamp to the range of the code, then scale; truncation matches integer microamps
    function [15:0] exp_ua(input [7:0] f, input [15:0] w);
        integer v, lo, hi, off, sp, fs;
        begin
            v = $signed(w);
            lo = 0;
            hi = 32511;
            off = 0;
            sp = 20000;
            fs = 27648;
            if (f[6])
            begin
                hi = 20480;
                fs = 16384;
            end
            if (!f[0])
            begin
                lo = -fs / 4;
                off = fs / 4;
                sp = 16000;
            end
            v = v < lo ? lo : (v > hi ? hi : v);
            exp_ua = ok(f) ? (v + off) * sp / fs : 0;
        end
    endfunction
    task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task rdb(input [7:0] n, input [4:0] x, input [7:0] e, input string nm);
    begin
        u_host.acc(1'b0, n, x, 8'h00, rd, st);
        chk(st, 2'h2, nm);
        chk(rd, e, nm);
    end
    endtask
    task wrb(input [7:0] n, input [4:0] x, input [7:0] v);
    begin
        u_host.acc(1'b1, n, x, v, rd, st);
        chk(st, 2'h2, "write ack");
    end
    endtask
    // byte 16 copies the ticker, the others return that copy
    task tick(output [31:0] t);
        integer j;
        for (j = 0; j < 4; j = j + 1)
        begin
            u_host.acc(1'b0, 8'h01, 5'h10 + j, 8'h00, rd, st);
            t[8*j +: 8] = rd;
        end
    endtask
    task give_verdict;
    begin
        $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    // ==========================================
    // watchdog and main sequence
    initial
    begin
        #500000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    initial
    begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        rdb(8'h80, 5'h00, 8'h31, "fn0 reset");
        rdb(8'h81, 5'h00, 8'h31, "fn1 reset");
        for (i = 0; i < 16; i = i + 1)
            rdb(8'h01, i, i < 10 ? DIAG[8*i +: 8] : 8'h00, "diag");
        for (i = 0; i < 4; i = i + 1)
            rdb(8'h00, i, DIAG[8*i +: 8], "short diag");
        u_host.acc(1'b0, 8'h00, 5'h04, 8'h00, rd, st);
        chk(st, 2'h1, "short end");
        u_host.acc(1'b1, 8'h01, 5'h00, 8'hAA, rd, st);
        chk(st, 2'h1, "diag write");
        u_host.acc(1'b0, 8'h82, 5'h00, 8'h00, rd, st);
        chk(st, 2'h1, "unmapped");
        // every code against corner words, then random words
        for (k = 0; k < 6; k = k + 1)
            for (i = 0; i < 12; i = i + 1)
            begin
                c = CODES[8*k +: 8];
                ch = i[0];
                d = i < 8 ? CORN[16*i +: 16] : $random(seed);
                wrb(8'h80 + ch, 5'h00, c);
                u_host.word(ch, d);
                repeat (2) @(negedge clk);
                chk(ch ? ua1 : ua0, exp_ua(c, d), "current");
                chk(act[ch], ok(c), "active");
                rdb(8'h80 + ch, 5'h00, c, "fn readback");
                rdb(8'h01, 5'h08 + ch, {7'h00, !ok(c) && c != 8'hFF}, "param err");
            end
        wrb(8'h80, 5'h00, 8'h31);
        wrb(8'h81, 5'h00, 8'h31);
        wrb(8'h00, 5'h01, 8'h01);
        wire_open = 2'h3;
        repeat (5) @(negedge clk);
        rdb(8'h01, 5'h08, 8'h10, "ch0 break");
        rdb(8'h01, 5'h09, 8'h00, "ch1 disabled");
        rdb(8'h01, 5'h07, 8'h01, "group");
        rdb(8'h01, 5'h00, 8'h06, "general");
        chk(led, 2'h1, "channel led");
        chk(grp, 1'b1, "group led");
        wrb(8'h00, 5'h01, 8'h02);
        repeat (5) @(negedge clk);
        rdb(8'h01, 5'h07, 8'h02, "group ch1");
        wire_open = 2'h0;
        repeat (5) @(negedge clk);
        rdb(8'h01, 5'h07, 8'h00, "group clear");
        chk(led, 2'h0, "channel led off");
        chk(grp, 1'b0, "group led off");
        diag_ovf = 1'b1;
        repeat (2) @(negedge clk);
        rdb(8'h01, 5'h03, 8'h08, "overflow");
        diag_ovf = 1'b0;
        comm_err = 1'b1;
        repeat (2) @(negedge clk);
        rdb(8'h01, 5'h03, 8'h10, "comm error");
        rdb(8'h01, 5'h00, 8'h01, "general int");
        comm_err = 1'b0;
        // function codes through the parameter record, then a mid-run reset
        wrb(8'h00, 5'h00, 8'h5A);
        wrb(8'h00, 5'h02, 8'h41);
        wrb(8'h00, 5'h03, 8'h40);
        rdb(8'h80, 5'h00, 8'h41, "fn0 via param");
        rdb(8'h81, 5'h00, 8'h40, "fn1 via param");
        wire_open = 2'h3;
        repeat (5) @(negedge clk);
        rdb(8'h01, 5'h09, 8'h10, "ch1 break");
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        rdb(8'h80, 5'h00, 8'h31, "fn0 after reset");
        rdb(8'h81, 5'h00, 8'h31, "fn1 after reset");
        repeat (3) @(negedge clk);
        // the enable byte is back to zero, so the open pin stays unreported
        rdb(8'h01, 5'h09, 8'h00, "enable after reset");
        wire_open = 2'h0;
        tick(t0);
        repeat (1000) @(negedge clk);
        tick(t1);
        chk((t1 - t0) >= 10 && (t1 - t0) <= 11, 1'b1, "ticker");
        give_verdict;
    end
endmodule // coutpd_tb
